// ===== shared/jtag_tap_map.svh
// Constants of the test access port: codes, lengths and boundary bit positions
`ifndef JTAG_TAP_MAP_SVH
`define JTAG_TAP_MAP_SVH

// ****************************************************************
// Instruction register
// ****************************************************************
`define IR_W 16
`define IR_RESET 16'h0000
`define IR_CAPTURE 16'h0001
`define IR_EXTEST 16'h0000
`define IR_SAMPLE 16'h0002
`define IR_IDCODE 16'h0004
`define IR_BYPASS 16'hFFFF
`define IR_FLASH_CTRL 16'h0082
`define IR_FLASH_DATA 16'h0083
`define IR_FLASH_ADDR 16'h0084
`define IR_FLASH_SCALE 16'h0085

// ****************************************************************
// Data registers
// ****************************************************************
`define IDCODE_W 32
`define FLASH_DR_NUM 4
`define BSR_LEN 134
`define BSR_RST_OE_SMALL 0
`define BSR_RST_IO_SMALL 1
`define BSR_RST_OE_LARGE 2
`define BSR_RST_IO_LARGE 3
`define BSR_EXT_CLK 4
`define BSR_WEAK_PULLUP 5
`define BSR_PIN_BASE 6
`define BSR_PINS 64

`endif

// ===== shared/jtag_tap_pkg.sv
// Types of the test access port
package jtag_tap_pkg;

   // ****************************************************************
   // Controller states, Gray coded in the order listed
   // ****************************************************************
   typedef enum logic [3:0] {
      TAP_RESET = 4'h0,
      TAP_IDLE = 4'h1,
      TAP_SEL_DR = 4'h3,
      TAP_CAP_DR = 4'h2,
      TAP_SHIFT_DR = 4'h6,
      TAP_EXIT1_DR = 4'h7,
      TAP_UPD_DR = 4'h5,
      TAP_PAUSE_DR = 4'h4,
      TAP_EXIT2_DR = 4'hC,
      TAP_SEL_IR = 4'hD,
      TAP_CAP_IR = 4'hF,
      TAP_SHIFT_IR = 4'hE,
      TAP_EXIT1_IR = 4'hA,
      TAP_UPD_IR = 4'hB,
      TAP_PAUSE_IR = 4'h9,
      TAP_EXIT2_IR = 4'h8
   } tap_state_e;

   // ****************************************************************
   // Selected data register
   // ****************************************************************
   typedef enum logic [2:0] {
      DR_BYPASS = 3'h0,
      DR_BOUNDARY = 3'h1,
      DR_IDCODE = 3'h2,
      DR_FLASH = 3'h3
   } dr_sel_e;

endpackage : jtag_tap_pkg

// ===== hdl/sync_two_flop.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module sync_two_flop #(
   parameter int WIDTH = 1
)(
   // Destination clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Levels
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;

endmodule : sync_two_flop

// ===== hdl/cdc_word_toggle.sv
// Word crossing by toggle event with held source data
`timescale 1ns/100ps
module cdc_word_toggle #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
   // Source side
   input wire logic src_clk_i,
   input wire logic src_rst_n_i,
   input wire logic src_load_i,
   input wire logic [WIDTH-1:0] src_data_i,
   // Destination side
   input wire logic dst_clk_i,
   input wire logic dst_rst_n_i,
   output logic [WIDTH-1:0] dst_data_o,
   output logic dst_valid_o
);

   logic [WIDTH-1:0] hold_reg;
   logic tog_reg;
   logic tog_sync;
   logic tog_seen_reg;
   logic [WIDTH-1:0] dst_reg;
   logic valid_reg;
   wire logic tog_edge;

   // Source holds the word stable until the next load
   always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
      if (!src_rst_n_i) begin
         hold_reg <= RESET_VAL;
         tog_reg <= 1'b0;
      end else if (src_load_i) begin
         hold_reg <= src_data_i;
         tog_reg <= ~tog_reg;
      end
   end

   sync_two_flop #(.WIDTH(1)) u_tog_sync (
      .clk_i(dst_clk_i),
      .rst_n_i(dst_rst_n_i),
      .d_i(tog_reg),
      .q_o(tog_sync)
   );

   assign tog_edge = tog_sync ^ tog_seen_reg;

   always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
      if (!dst_rst_n_i) begin
         tog_seen_reg <= 1'b0;
         dst_reg <= RESET_VAL;
         valid_reg <= 1'b0;
      end else begin
         tog_seen_reg <= tog_sync;
         valid_reg <= tog_edge;
         if (tog_edge) begin
            dst_reg <= hold_reg;
         end
      end
   end

   assign dst_data_o = dst_reg;
   assign dst_valid_o = valid_reg;

endmodule : cdc_word_toggle

// ===== hdl/jtag_tap_boundary_scan.sv
// Test access port with instruction register, boundary chain and data registers
// How it works
// R1: Only the four test pins reach the test logic. The system reset nrst_i also resets it.
// R2: Scans follow the standard controller states.
// R3: 16-bit instruction register resets to zero, selects the data register.
// R4: 0000 external test, 0002 sample/preload, 0004 identification.
// R5: Eight instructions; all-ones code selects one-stage bypass.
// R6: Codes 0082 to 0085 select four flash-access registers.
// R7: 134-bit boundary chain, usable by both boundary instructions.
// R8: External test captures and updates the pins; sample captures and only preloads the update stage.
// R9: Small package: bit 0 reset drive enable, bit 1 reset value.
// R10: Large package: bits 2 and 3 take the reset pin roles.
// R11: Bit 4 captures the external clock pin; no update.
// R12: Bit 5 carries the weak pullup enable for all pins.
// R13: Even bits 6 to 20 are port 0 output enables.
// R14: Odd bits from 7 capture port 0 pin levels.
// R15: Odd port 0 bits drive the pin values on update.
// R16: During external test all pin inputs to the core are one.
// R17: Identification selects a 32-bit identification register.
// R18: Remaining ports continue the even enable, odd value pattern.
// R19: Unknown codes act as bypass.
`timescale 1ns/100ps
`include "jtag_tap_map.svh"
module jtag_tap_boundary_scan #(
   parameter bit LARGE_PACKAGE = 1'b1,
   parameter logic [31:0] IDCODE_VALUE = 32'h0000_1001, // Arbitrary value, bit 0 set
   parameter int FLASH_DR_W = 8
)(
   // System clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Test access pins
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   // Port pins
   input wire logic [`BSR_PINS-1:0] port_pin_i,
   output logic [`BSR_PINS-1:0] port_pin_o,
   output logic [`BSR_PINS-1:0] port_pin_oe_o,
   // Reset and clock pins
   input wire logic rst_pin_i,
   output logic rst_pin_o,
   output logic rst_pin_oe_o,
   input wire logic ext_clk_pin_i,
   // Core side
   input wire logic [`BSR_PINS-1:0] core_port_out_i,
   input wire logic [`BSR_PINS-1:0] core_port_oe_i,
   output logic [`BSR_PINS-1:0] core_port_in_o,
   input wire logic core_rst_drive_i,
   output logic core_rst_in_o,
   input wire logic core_weak_pullup_i,
   output logic weak_pullup_en_o,
   output logic ext_test_active_o
);

   localparam int NP = `BSR_PINS;
   localparam int BL = `BSR_LEN;
   localparam int CAP_W = 2 * NP + 4;
   localparam int RST_OE_BIT = LARGE_PACKAGE ? `BSR_RST_OE_LARGE : `BSR_RST_OE_SMALL;
   localparam int RST_IO_BIT = LARGE_PACKAGE ? `BSR_RST_IO_LARGE : `BSR_RST_IO_SMALL;

   // ****************************************************************
   // Reset release in both domains
   // ****************************************************************
   logic [1:0] ref_rst_sync_reg;
   logic [1:0] tck_rst_sync_reg;

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ref_rst_sync_reg <= 2'h0;
      end else begin
         ref_rst_sync_reg <= {ref_rst_sync_reg[0], 1'b1};
      end
   end

   always_ff @(posedge tck_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tck_rst_sync_reg <= 2'h0;
      end else begin
         tck_rst_sync_reg <= {tck_rst_sync_reg[0], 1'b1};
      end
   end

   wire logic ref_rst_n = ref_rst_sync_reg[1];
   wire logic tck_rst_n = tck_rst_sync_reg[1];

   // ****************************************************************
   // Controller state machine
   // ****************************************************************
   jtag_tap_pkg::tap_state_e state_reg;
   jtag_tap_pkg::tap_state_e state_next;

   always_comb begin // R2
      state_next = state_reg;
      unique case (state_reg)
         jtag_tap_pkg::TAP_RESET:
            state_next = tms_i ? jtag_tap_pkg::TAP_RESET : jtag_tap_pkg::TAP_IDLE;
         jtag_tap_pkg::TAP_IDLE:
            state_next = tms_i ? jtag_tap_pkg::TAP_SEL_DR : jtag_tap_pkg::TAP_IDLE;
         jtag_tap_pkg::TAP_SEL_DR:
            state_next = tms_i ? jtag_tap_pkg::TAP_SEL_IR : jtag_tap_pkg::TAP_CAP_DR;
         jtag_tap_pkg::TAP_CAP_DR:
            state_next = tms_i ? jtag_tap_pkg::TAP_EXIT1_DR : jtag_tap_pkg::TAP_SHIFT_DR;
         jtag_tap_pkg::TAP_SHIFT_DR:
            state_next = tms_i ? jtag_tap_pkg::TAP_EXIT1_DR : jtag_tap_pkg::TAP_SHIFT_DR;
         jtag_tap_pkg::TAP_EXIT1_DR:
            state_next = tms_i ? jtag_tap_pkg::TAP_UPD_DR : jtag_tap_pkg::TAP_PAUSE_DR;
         jtag_tap_pkg::TAP_PAUSE_DR:
            state_next = tms_i ? jtag_tap_pkg::TAP_EXIT2_DR : jtag_tap_pkg::TAP_PAUSE_DR;
         jtag_tap_pkg::TAP_EXIT2_DR:
            state_next = tms_i ? jtag_tap_pkg::TAP_UPD_DR : jtag_tap_pkg::TAP_SHIFT_DR;
         jtag_tap_pkg::TAP_UPD_DR:
            state_next = tms_i ? jtag_tap_pkg::TAP_SEL_DR : jtag_tap_pkg::TAP_IDLE;
         jtag_tap_pkg::TAP_SEL_IR:
            state_next = tms_i ? jtag_tap_pkg::TAP_RESET : jtag_tap_pkg::TAP_CAP_IR;
         jtag_tap_pkg::TAP_CAP_IR:
            state_next = tms_i ? jtag_tap_pkg::TAP_EXIT1_IR : jtag_tap_pkg::TAP_SHIFT_IR;
         jtag_tap_pkg::TAP_SHIFT_IR:
            state_next = tms_i ? jtag_tap_pkg::TAP_EXIT1_IR : jtag_tap_pkg::TAP_SHIFT_IR;
         jtag_tap_pkg::TAP_EXIT1_IR:
            state_next = tms_i ? jtag_tap_pkg::TAP_UPD_IR : jtag_tap_pkg::TAP_PAUSE_IR;
         jtag_tap_pkg::TAP_PAUSE_IR:
            state_next = tms_i ? jtag_tap_pkg::TAP_EXIT2_IR : jtag_tap_pkg::TAP_PAUSE_IR;
         jtag_tap_pkg::TAP_EXIT2_IR:
            state_next = tms_i ? jtag_tap_pkg::TAP_UPD_IR : jtag_tap_pkg::TAP_SHIFT_IR;
         jtag_tap_pkg::TAP_UPD_IR:
            state_next = tms_i ? jtag_tap_pkg::TAP_SEL_DR : jtag_tap_pkg::TAP_IDLE;
      endcase
   end

   always_ff @(posedge tck_i or negedge tck_rst_n) begin // R1
      if (!tck_rst_n) begin
         state_reg <= jtag_tap_pkg::TAP_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   wire logic st_reset = (state_reg == jtag_tap_pkg::TAP_RESET);
   wire logic st_cap_ir = (state_reg == jtag_tap_pkg::TAP_CAP_IR);
   wire logic st_sh_ir = (state_reg == jtag_tap_pkg::TAP_SHIFT_IR);
   wire logic st_upd_ir = (state_reg == jtag_tap_pkg::TAP_UPD_IR);
   wire logic st_cap_dr = (state_reg == jtag_tap_pkg::TAP_CAP_DR);
   wire logic st_sh_dr = (state_reg == jtag_tap_pkg::TAP_SHIFT_DR);
   wire logic st_upd_dr = (state_reg == jtag_tap_pkg::TAP_UPD_DR);

   // ****************************************************************
   // Instruction register and decode
   // ****************************************************************
   logic [`IR_W-1:0] ir_sr_reg;
   logic [`IR_W-1:0] ir_reg;

   always_ff @(posedge tck_i or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         ir_sr_reg <= `IR_RESET;
         ir_reg <= `IR_RESET; // R3
      end else begin
         if (st_cap_ir) begin
            ir_sr_reg <= `IR_CAPTURE;
         end else if (st_sh_ir) begin
            ir_sr_reg <= {tdi_i, ir_sr_reg[`IR_W-1:1]}; // R2
         end
         if (st_reset) begin
            ir_reg <= `IR_RESET; // R3
         end else if (st_upd_ir) begin
            ir_reg <= ir_sr_reg;
         end
      end
   end

   wire logic ir_extest = (ir_reg == `IR_EXTEST); // R4
   wire logic ir_sample = (ir_reg == `IR_SAMPLE); // R4
   wire logic ir_idcode = (ir_reg == `IR_IDCODE); // R4
   wire logic ir_flash = (ir_reg >= `IR_FLASH_CTRL) && (ir_reg <= `IR_FLASH_SCALE); // R6
   wire logic [1:0] flash_idx = ir_reg[1:0] - 2'h2; // R6
   wire jtag_tap_pkg::dr_sel_e dr_sel =
      (ir_extest | ir_sample) ? jtag_tap_pkg::DR_BOUNDARY : // R7
      ir_idcode ? jtag_tap_pkg::DR_IDCODE : // R17
      ir_flash ? jtag_tap_pkg::DR_FLASH : // R6
      jtag_tap_pkg::DR_BYPASS; // R5 R19

   // ****************************************************************
   // Capture of pins and core signals into the test clock domain
   // ****************************************************************
   logic [CAP_W-1:0] cap_raw;
   logic [CAP_W-1:0] cap_sync;
   logic [BL-1:0] bsr_cap;

   assign cap_raw = {core_weak_pullup_i, ext_clk_pin_i, rst_pin_i, core_rst_drive_i,
                     port_pin_i, core_port_oe_i};

   sync_two_flop #(.WIDTH(CAP_W)) u_cap_sync (
      .clk_i(tck_i),
      .rst_n_i(tck_rst_n),
      .d_i(cap_raw),
      .q_o(cap_sync)
   );

   assign bsr_cap[`BSR_RST_OE_SMALL] = LARGE_PACKAGE ? 1'b0 : cap_sync[2*NP]; // R9
   assign bsr_cap[`BSR_RST_IO_SMALL] = LARGE_PACKAGE ? 1'b0 : cap_sync[2*NP+1]; // R9
   assign bsr_cap[`BSR_RST_OE_LARGE] = LARGE_PACKAGE ? cap_sync[2*NP] : 1'b0; // R10
   assign bsr_cap[`BSR_RST_IO_LARGE] = LARGE_PACKAGE ? cap_sync[2*NP+1] : 1'b0; // R10
   assign bsr_cap[`BSR_EXT_CLK] = cap_sync[2*NP+2]; // R11
   assign bsr_cap[`BSR_WEAK_PULLUP] = cap_sync[2*NP+3]; // R12

   // ****************************************************************
   // Data registers
   // ****************************************************************
   logic [BL-1:0] bsr_sr_reg;
   logic [BL-1:0] bsr_upd_reg;
   logic bypass_reg;
   logic [`IDCODE_W-1:0] id_sr_reg;
   logic [FLASH_DR_W-1:0] flash_sr_reg;
   logic [FLASH_DR_W-1:0] flash_store_reg [`FLASH_DR_NUM];

   always_ff @(posedge tck_i or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         bsr_sr_reg <= '0;
         bsr_upd_reg <= '0;
      end else begin
         if (st_cap_dr && dr_sel == jtag_tap_pkg::DR_BOUNDARY) begin
            bsr_sr_reg <= bsr_cap; // R8
         end else if (st_sh_dr && dr_sel == jtag_tap_pkg::DR_BOUNDARY) begin
            bsr_sr_reg <= {tdi_i, bsr_sr_reg[BL-1:1]}; // R7
         end
         if (st_upd_dr && dr_sel == jtag_tap_pkg::DR_BOUNDARY) begin
            bsr_upd_reg <= bsr_sr_reg; // R8
         end
      end
   end

   always_ff @(posedge tck_i or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         bypass_reg <= 1'b0;
         id_sr_reg <= '0;
      end else begin
         if (st_cap_dr) begin
            bypass_reg <= 1'b0;
            id_sr_reg <= IDCODE_VALUE; // R17
         end else if (st_sh_dr) begin
            bypass_reg <= tdi_i; // R5
            id_sr_reg <= {tdi_i, id_sr_reg[`IDCODE_W-1:1]}; // R17
         end
      end
   end

   always_ff @(posedge tck_i or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         flash_sr_reg <= '0;
         for (int i = 0; i < `FLASH_DR_NUM; i++) begin
            flash_store_reg[i] <= '0;
         end
      end else if (dr_sel == jtag_tap_pkg::DR_FLASH) begin
         if (st_cap_dr) begin
            flash_sr_reg <= flash_store_reg[flash_idx]; // R6
         end else if (st_sh_dr) begin
            flash_sr_reg <= {tdi_i, flash_sr_reg[FLASH_DR_W-1:1]};
         end else if (st_upd_dr) begin
            flash_store_reg[flash_idx] <= flash_sr_reg; // R6
         end
      end
   end

   // ****************************************************************
   // Data out, changed on the falling test clock edge
   // ****************************************************************
   logic tdo_reg;
   logic tdo_oe_reg;
   wire logic dr_bit;

   assign dr_bit = (dr_sel == jtag_tap_pkg::DR_BOUNDARY) ? bsr_sr_reg[0] :
                   (dr_sel == jtag_tap_pkg::DR_IDCODE) ? id_sr_reg[0] :
                   (dr_sel == jtag_tap_pkg::DR_FLASH) ? flash_sr_reg[0] : bypass_reg;

   always_ff @(negedge tck_i or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         tdo_reg <= 1'b0;
         tdo_oe_reg <= 1'b0;
      end else begin
         tdo_reg <= st_sh_ir ? ir_sr_reg[0] : dr_bit; // R1
         tdo_oe_reg <= st_sh_ir | st_sh_dr;
      end
   end

   assign tdo_o = tdo_reg;
   assign tdo_oe_o = tdo_oe_reg;

   // ****************************************************************
   // Update stage and mode handed to the system clock domain
   // ****************************************************************
   logic [BL:0] upd_ref;
   // Taken on the update edge itself, as the test clock may stop after it
   wire logic send = st_upd_dr | st_upd_ir | st_reset;
   wire logic extest_next = st_reset | (st_upd_ir ? (ir_sr_reg == `IR_EXTEST) : ir_extest);
   wire logic [BL-1:0] upd_next =
      (st_upd_dr && dr_sel == jtag_tap_pkg::DR_BOUNDARY) ? bsr_sr_reg : bsr_upd_reg;

   cdc_word_toggle #(.WIDTH(BL + 1), .RESET_VAL({1'b1, {BL{1'b0}}})) u_upd_cdc (
      .src_clk_i(tck_i),
      .src_rst_n_i(tck_rst_n),
      .src_load_i(send),
      .src_data_i({extest_next, upd_next}),
      .dst_clk_i(ref_clk_i),
      .dst_rst_n_i(ref_rst_n),
      .dst_data_o(upd_ref),
      .dst_valid_o()
   );

   wire logic extest_ref = upd_ref[BL]; // R8

   // ****************************************************************
   // Pin inputs toward the core
   // ****************************************************************
   logic [NP:0] pin_sync;

   sync_two_flop #(.WIDTH(NP + 1)) u_pin_sync (
      .clk_i(ref_clk_i),
      .rst_n_i(ref_rst_n),
      .d_i({rst_pin_i, port_pin_i}),
      .q_o(pin_sync)
   );

   // ****************************************************************
   // Per-pin boundary cells
   // ****************************************************************
   logic [NP-1:0] pin_out_next;
   logic [NP-1:0] pin_oe_next;
   logic [NP-1:0] core_in_next;

   for (genvar k = 0; k < NP; k++) begin : g_cell
      assign bsr_cap[`BSR_PIN_BASE + 2*k] = cap_sync[k]; // R13 R18
      assign bsr_cap[`BSR_PIN_BASE + 2*k + 1] = cap_sync[NP + k]; // R14 R18
      assign pin_oe_next[k] = extest_ref ? upd_ref[`BSR_PIN_BASE + 2*k] :
                              core_port_oe_i[k]; // R13 R18
      assign pin_out_next[k] = extest_ref ? upd_ref[`BSR_PIN_BASE + 2*k + 1] :
                               core_port_out_i[k]; // R15 R18
      assign core_in_next[k] = extest_ref | pin_sync[k]; // R16
   end

   // ****************************************************************
   // Pin and core output registers
   // ****************************************************************
   logic [NP-1:0] pin_out_reg;
   logic [NP-1:0] pin_oe_reg;
   logic [NP-1:0] core_in_reg;
   logic rst_oe_reg;
   logic rst_out_reg;
   logic core_rst_in_reg;
   logic pullup_reg;

   always_ff @(posedge ref_clk_i or negedge ref_rst_n) begin
      if (!ref_rst_n) begin
         pin_out_reg <= '0;
         pin_oe_reg <= '0;
         core_in_reg <= '1;
         rst_oe_reg <= 1'b0;
         rst_out_reg <= 1'b0;
         core_rst_in_reg <= 1'b1;
         pullup_reg <= 1'b0;
      end else begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
         core_in_reg <= core_in_next;
         rst_oe_reg <= extest_ref ? upd_ref[RST_OE_BIT] : core_rst_drive_i; // R9 R10
         rst_out_reg <= extest_ref ? upd_ref[RST_IO_BIT] : 1'b0; // R9 R10
         core_rst_in_reg <= extest_ref | pin_sync[NP]; // R16
         pullup_reg <= extest_ref ? upd_ref[`BSR_WEAK_PULLUP] : core_weak_pullup_i; // R12
      end
   end

   assign port_pin_o = pin_out_reg;
   assign port_pin_oe_o = pin_oe_reg;
   assign core_port_in_o = core_in_reg;
   assign rst_pin_oe_o = rst_oe_reg;
   assign rst_pin_o = rst_out_reg;
   assign core_rst_in_o = core_rst_in_reg;
   assign weak_pullup_en_o = pullup_reg;
   assign ext_test_active_o = extest_ref;

endmodule : jtag_tap_boundary_scan

// ===== verif/jtag_tap_boundary_scan_checker.sv
// Assertions on the pin and core side of the test access port
`timescale 1ns/100ps
`include "jtag_tap_map.svh"
module jtag_tap_boundary_scan_checker (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Pins
   input wire logic [`BSR_PINS-1:0] port_pin_i,
   input wire logic [`BSR_PINS-1:0] port_pin_o,
   input wire logic [`BSR_PINS-1:0] port_pin_oe_o,
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe_o,
   // Core side
   input wire logic [`BSR_PINS-1:0] core_port_out_i,
   input wire logic [`BSR_PINS-1:0] core_port_oe_i,
   input wire logic [`BSR_PINS-1:0] core_port_in_o,
   input wire logic core_rst_drive_i,
   input wire logic core_rst_in_o,
   input wire logic core_weak_pullup_i,
   input wire logic weak_pullup_en_o,
   input wire logic ext_test_active_o
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_core;
      !ext_test_active_o && $stable(core_port_out_i) && $stable(core_port_oe_i)
         && $stable(core_weak_pullup_i) && $stable(core_rst_drive_i) && $stable(port_pin_i);
   endsequence
   property p_ones; ext_test_active_o [*3] |-> &core_port_in_o; endproperty
   property p_rst_in; ext_test_active_o [*3] |-> core_rst_in_o; endproperty
   property p_pin_o; s_core [*6] |-> port_pin_o == core_port_out_i; endproperty
   property p_pin_oe; s_core [*6] |-> port_pin_oe_o == core_port_oe_i; endproperty
   property p_pull; s_core [*6] |-> weak_pullup_en_o == core_weak_pullup_i; endproperty
   property p_rst_oe; s_core [*6] |-> rst_pin_oe_o == core_rst_drive_i; endproperty
   property p_rst_o; s_core [*6] |-> !rst_pin_o; endproperty
   property p_core_in; s_core [*6] |-> core_port_in_o == port_pin_i; endproperty
   a_ones: assert property (p_ones) else $error("core pins not high");
   a_rst_in: assert property (p_rst_in) else $error("core reset in not high");
   a_pin_o: assert property (p_pin_o) else $error("pin value not from core");
   a_pin_oe: assert property (p_pin_oe) else $error("pin enable not from core");
   a_pull: assert property (p_pull) else $error("pullup not from core");
   a_rst_oe: assert property (p_rst_oe) else $error("reset enable not from core");
   a_rst_o: assert property (p_rst_o) else $error("reset pin driven high");
   a_core_in: assert property (p_core_in) else $error("pin levels not passed");
   c_fell: cover property ($fell(ext_test_active_o));
   c_rose: cover property ($rose(ext_test_active_o));
   c_core: cover property (s_core [*6]);
endmodule : jtag_tap_boundary_scan_checker

// ===== verif/jtag_host_model.sv
// Behavioural test controller driving three of the four test pins and reading data out
`timescale 1ns/100ps
module jtag_host_model (
   // Test pins
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   input wire logic tdo_i
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   // One test clock, data out taken before the rising edge
   task automatic step(input logic m, input logic d, output logic q);
      tms_o = m;
      tdi_o = d;
      #32;
      q = tdo_i;
      tck_o = 1'b1;
      #32;
      tck_o = 1'b0;
   endtask : step
   task automatic reset();
      logic q;
      #3;
      for (int i = 0; i < 7; i++) begin
         step(i < 6, ~tdi_o, q);
      end
   endtask : reset
   // From idle with three idle clocks, shift n bits, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [133:0] din,
                       output logic [133:0] dout);
      logic q;
      logic [6:0] seq;
      seq = ir ? 7'b0011000 : 7'b0001000;
      dout = '0;
      for (int i = 0; i < (ir ? 7 : 6); i++) begin
         step(seq[i], ~tdi_o, q);
      end
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, ~tdi_o, q);
      step(1'b0, ~tdi_o, q);
   endtask : scan
endmodule : jtag_host_model

// ===== verif/test_jtag_tap_boundary_scan.sv
// Self-checking bench for the test access port
`timescale 1ns/100ps
`include "jtag_tap_map.svh"
module test_jtag_tap_boundary_scan;
   localparam logic [31:0] ID_VAL = 32'h0ABC_5001; // Arbitrary value
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, rst_pin_i, rst_pin_o, rst_pin_oe_o;
   logic ext_clk_pin_i, core_rst_drive_i, core_rst_in_o, core_weak_pullup_i;
   logic weak_pullup_en_o, ext_test_active_o;
   logic [`BSR_PINS-1:0] port_pin_i, port_pin_o, port_pin_oe_o, e_oe, e_out;
   logic [`BSR_PINS-1:0] core_port_out_i, core_port_oe_i, core_port_in_o;
   logic [133:0] din, dout, d0;
   logic [15:0] codes [6] = '{`IR_BYPASS, 16'h1234, 16'h0082, 16'h0083, 16'h0084, 16'h0085};
   int error_cnt = 0;
   int n_compared = 0;
   always #4 ref_clk_i = ~ref_clk_i;
   jtag_tap_boundary_scan #(.IDCODE_VALUE(ID_VAL)) i_dut (.ref_clk_i, .nrst_i, .tck_i, .tms_i,
      .tdi_i, .tdo_o, .tdo_oe_o, .port_pin_i, .port_pin_o, .port_pin_oe_o, .rst_pin_i,
      .rst_pin_o, .rst_pin_oe_o, .ext_clk_pin_i, .core_port_out_i, .core_port_oe_i,
      .core_port_in_o, .core_rst_drive_i, .core_rst_in_o, .core_weak_pullup_i,
      .weak_pullup_en_o, .ext_test_active_o);
   jtag_host_model i_host (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o));
   task automatic chk(input logic [133:0] got, exp, input int n, input string msg);
      logic [133:0] m;
      m = (134'(1) << n) - 134'(1);
      n_compared++;
      if ((got & m) !== (exp & m)) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask : chk
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize
   task automatic set_in();
      core_port_out_i = {$urandom, $urandom};
      core_port_oe_i = {$urandom, $urandom};
      port_pin_i = {$urandom, $urandom};
      {rst_pin_i, ext_clk_pin_i, core_rst_drive_i, core_weak_pullup_i} = 4'($urandom);
   endtask : set_in
   function automatic logic [133:0] bsr_exp();
      logic [133:0] v;
      v = '0;
      v[`BSR_RST_OE_LARGE] = core_rst_drive_i;
      v[`BSR_RST_IO_LARGE] = rst_pin_i;
      v[`BSR_EXT_CLK] = ext_clk_pin_i;
      v[`BSR_WEAK_PULLUP] = core_weak_pullup_i;
      for (int k = 0; k < `BSR_PINS; k++) begin
         v[`BSR_PIN_BASE + 2 * k] = core_port_oe_i[k];
         v[`BSR_PIN_BASE + 2 * k + 1] = port_pin_i[k];
      end
      return v;
   endfunction : bsr_exp
   task automatic ir(input logic [15:0] code);
      i_host.scan(1'b1, 16, 134'(code), dout);
      chk(dout, 134'(`IR_CAPTURE), 16, "ir capture");
   endtask : ir
   task automatic dr(input int n);
      din = {6'($urandom), $urandom, $urandom, $urandom, $urandom};
      i_host.scan(1'b0, n, din, dout);
   endtask : dr
   initial begin
      void'($urandom(95412));
      set_in();
      repeat (2) @(negedge ref_clk_i);
      nrst_i = 1'b1;
      i_host.reset();
      foreach (codes[i]) begin
         ir(codes[i]);
         dr(9);
         d0 = din >> 1;
         if (i < 2) chk(dout, din << 1, 9, "bypass");
         else dr(8);
         if (i >= 2) chk(dout, d0, 8, "flash reg");
      end
      $display("bypass and flash tests done");
      ir(`IR_IDCODE);
      dr(32);
      chk(dout, 134'(ID_VAL), 32, "idcode");
      $display("idcode test done");
      repeat (2) begin
         @(negedge ref_clk_i);
         set_in();
         ir(`IR_EXTEST);
         dr(`BSR_LEN);
         chk(dout, bsr_exp(), 134, "ext capture");
         repeat (20) @(negedge ref_clk_i);
         for (int k = 0; k < `BSR_PINS; k++) begin
            e_oe[k] = din[`BSR_PIN_BASE + 2 * k];
            e_out[k] = din[`BSR_PIN_BASE + 2 * k + 1];
         end
         chk(134'(port_pin_oe_o), 134'(e_oe), 64, "pin enable");
         chk(134'(port_pin_o), 134'(e_out), 64, "pin value");
         chk(134'({weak_pullup_en_o, rst_pin_oe_o, rst_pin_o}), 134'({din[5], din[2], din[3]}), 3,
             "misc update");
         chk(134'({core_port_in_o, core_rst_in_o}), '1, 65, "core inputs");
         ir(`IR_SAMPLE);
         dr(`BSR_LEN);
         chk(dout, bsr_exp(), 134, "sample capture");
         repeat (20) @(negedge ref_clk_i);
         chk(134'({port_pin_oe_o, port_pin_o}), 134'({core_port_oe_i, core_port_out_i}), 128,
             "sample pins");
         $display("boundary test done");
      end
      summarize();
   end
   initial begin
      #400000;
      error_cnt++;
      summarize();
   end
endmodule : test_jtag_tap_boundary_scan
bind jtag_tap_boundary_scan jtag_tap_boundary_scan_checker i_chk (.ref_clk_i, .nrst_i,
   .port_pin_i, .port_pin_o, .port_pin_oe_o, .rst_pin_o, .rst_pin_oe_o, .core_port_out_i,
   .core_port_oe_i, .core_port_in_o, .core_rst_drive_i, .core_rst_in_o,
   .core_weak_pullup_i, .weak_pullup_en_o, .ext_test_active_o);
